/* File: hw/updown_pkg.sv */
// Shared constants for the presettable up/down counter block.
`default_nettype none

package updown_pkg;

  // ****************************************************************
  // Counter geometry
  // ****************************************************************
  localparam int          STATE_W    = 4;
  localparam logic [3:0]  DECADE_MAX = 4'h9;
  localparam logic [3:0]  BINARY_MAX = 4'hf;
  localparam logic [3:0]  STATE_ZERO = 4'h0;
  localparam logic [3:0]  STATE_RST  = 4'h0;

  // ****************************************************************
  // Clock
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 8;

  // ****************************************************************
  // Register map, byte addresses on a 32-bit bus
  // ****************************************************************
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK  = 4'hc;

  // Control register fields.
  localparam int          CTRL_INHIBIT   = 0;
  localparam logic [0:0]  CTRL_RST_VAL   = 1'h0;

  // Status register fields.
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_TC        = 4;
  localparam int          STAT_DOWN      = 5;
  localparam int          STAT_INHIBIT   = 6;
  localparam int          STAT_RIPPLE_N  = 7;

  // Interrupt sources, shared by the status and mask registers.
  localparam int          IRQ_N          = 3;
  localparam int          IRQ_TC_RISE    = 0;
  localparam int          IRQ_RIPPLE     = 1;
  localparam int          IRQ_PRESET     = 2;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

endpackage

`default_nettype wire

/* File: hw/sync2.sv */
// Two flip-flop synchroniser for pin inputs, one per bit.
`default_nettype none

module sync2 #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] INIT  = 32'h0000_0000
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1 || WIDTH > 32) begin
      $error("sync2: WIDTH must lie between 1 and 32.");
    end
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q   <= INIT[WIDTH-1:0];
      sync_out <= INIT[WIDTH-1:0];
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sync2

`default_nettype wire

/* File: hw/count_step.sv */
// Next-state and terminal decode of a 4-bit decade or binary counter.
`default_nettype none

module count_step #(
  parameter bit DECADE = 1'b1
) (
  input  wire logic [3:0] state,
  input  wire logic       down,
  output logic      [3:0] next_state,
  output logic            at_terminal
);

  // Highest legal value of the selected variant.
  function automatic logic [3:0] top_value(input bit decade);
    return decade ? updown_pkg::DECADE_MAX : updown_pkg::BINARY_MAX;
  endfunction

  logic [3:0] top;

  assign top = top_value(DECADE);

  // Terminal count looks only at the state and the direction.
  always_comb begin
    if (down) begin
      at_terminal = (state == updown_pkg::STATE_ZERO);
    end else begin
      at_terminal = (state == top);
    end
  end

  // An out-of-range decade preset rejoins the sequence in one step.
  always_comb begin
    if (down) begin
      if (state == updown_pkg::STATE_ZERO || state > top) begin
        next_state = top;
      end else begin
        next_state = 4'(state - 4'h1);
      end
    end else begin
      if (state >= top) begin
        next_state = updown_pkg::STATE_ZERO;
      end else begin
        next_state = 4'(state + 4'h1);
      end
    end
  end

endmodule // count_step

`default_nettype wire

/* File: hw/updown_counter.sv */
// Presettable 4-bit up/down counter with an Avalon-MM register port.
//
// Operation
// - Counting steps only on rising count clock edges; preset load acts at any time.
// - Decade counts 0 to 9; binary 0 to 15.
// - Four state bits with preset, increment, decrement.
// - Low load copies preset inputs, overriding everything.
// - High inhibit holds the state.
// - Inhibit low: step up if direction low, else down.
// - Terminal high at zero down or maximum up.
// - Terminal decodes only state and direction.
// - Terminal ignores this stage's own inhibit.
// - Ripple low from falling to next rising edge.
// - Ripple stays high on inhibit or no terminal.
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`default_nettype none

module updown_counter #(
  parameter bit DECADE  = 1'b1,
  parameter int STATE_W = updown_pkg::STATE_W
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Counter pins.
  input  wire logic        clock_pulse,
  input  wire logic        count_inhibit,
  input  wire logic        down_select,
  input  wire logic        preset_load_n,
  input  wire logic [3:0]  preset_inputs,
  output logic      [3:0]  state_outputs,
  output logic             terminal_count,
  output logic             ripple_clock_out,
  // Avalon-MM slave.
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Interrupt.
  output logic             irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial begin
    if (STATE_W != updown_pkg::STATE_W) begin
      $error("updown_counter: only a 4-bit state is supported.");
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Every pin is foreign to clk, so each passes two flip-flops. This
  // costs two cycles of latency, including on the preset path.
  localparam int PIN_W = 8;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic             cp_s;
  logic             inhibit_pin_s;
  logic             down_s;
  logic             load_n_s;
  logic [3:0]       preset_s;

  assign pins_raw = {preset_inputs, preset_load_n, down_select,
                     count_inhibit, clock_pulse};

  sync2 #(
    .WIDTH (PIN_W),
    .INIT  (32'h0000_0008)
  ) u_pin_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign cp_s          = pins_s[0];
  assign inhibit_pin_s = pins_s[1];
  assign down_s        = pins_s[2];
  assign load_n_s      = pins_s[3];
  assign preset_s      = pins_s[7:4];

  // ****************************************************************
  // Count clock edge detection
  // ****************************************************************
  logic cp_prev_q;
  logic cp_rise;
  logic cp_fall;

  always_ff @(posedge clk) begin
    if (rst) begin
      cp_prev_q <= 1'b0;
    end else begin
      cp_prev_q <= cp_s;
    end
  end

  assign cp_rise = cp_s & ~cp_prev_q;
  assign cp_fall = ~cp_s & cp_prev_q;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Software inhibit is ORed with the pin so a host can freeze the
  // chain without touching the board logic.
  logic ctrl_inhibit_q;
  logic inhibit;

  assign inhibit = inhibit_pin_s | ctrl_inhibit_q;

  // ****************************************************************
  // Counter state
  // ****************************************************************
  logic [3:0] state_q;
  logic [3:0] step_state;
  logic       tc_int;

  count_step #(
    .DECADE (DECADE)
  ) u_step (
    .state       (state_q),
    .down        (down_s),
    .next_state  (step_state),
    .at_terminal (tc_int)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= updown_pkg::STATE_RST;
    end else if (!load_n_s) begin
      state_q <= preset_s;
    end else if (cp_rise && !inhibit) begin
      state_q <= step_state;
    end else begin
      state_q <= state_q;
    end
  end

  assign state_outputs = state_q;

  // ****************************************************************
  // Terminal count
  // ****************************************************************
  // Registered copy of the decode so the pin cannot glitch; it still
  // follows only the state and the direction, never the inhibit.
  logic tc_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      tc_q <= 1'b0;
    end else begin
      tc_q <= tc_int;
    end
  end

  assign terminal_count = tc_q;

  // ****************************************************************
  // Ripple clock
  // ****************************************************************
  logic ripple_low_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      ripple_low_q <= 1'b0;
    end else if (inhibit || !tc_int || !load_n_s) begin
      ripple_low_q <= 1'b0;
    end else if (cp_rise) begin
      ripple_low_q <= 1'b0;
    end else if (cp_fall) begin
      ripple_low_q <= 1'b1;
    end else begin
      ripple_low_q <= ripple_low_q;
    end
  end

  assign ripple_clock_out = ~ripple_low_q;

  // ****************************************************************
  // Interrupt events
  // ****************************************************************
  logic             tc_prev_q;
  logic             ripple_prev_q;
  logic             load_prev_n_q;
  logic [updown_pkg::IRQ_N-1:0] irq_event;

  always_ff @(posedge clk) begin
    if (rst) begin
      tc_prev_q     <= 1'b0;
      ripple_prev_q <= 1'b0;
      load_prev_n_q <= 1'b1;
    end else begin
      tc_prev_q     <= tc_q;
      ripple_prev_q <= ripple_low_q;
      load_prev_n_q <= load_n_s;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[updown_pkg::IRQ_TC_RISE] = tc_q & ~tc_prev_q;
    irq_event[updown_pkg::IRQ_RIPPLE]  = ripple_low_q & ~ripple_prev_q;
    irq_event[updown_pkg::IRQ_PRESET]  = ~load_n_s & load_prev_n_q;
  end

  // ****************************************************************
  // Avalon-MM slave handshake
  // ****************************************************************
  // Every access takes two cycles: the first latches read data, the
  // second drops waitrequest and commits writes.
  logic req;
  logic ack_q;
  logic commit;
  logic wr_commit;

  assign req         = read | write;
  assign waitrequest = req & ~ack_q;
  assign commit      = req & ack_q;
  assign wr_commit   = commit & write & byteenable[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function automatic logic hit(input logic [3:0] addr,
                               input logic [3:0] offset);
    return addr == offset;
  endfunction

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  logic [updown_pkg::IRQ_N-1:0] irq_stat_q;
  logic [updown_pkg::IRQ_N-1:0] irq_mask_q;
  logic [updown_pkg::IRQ_N-1:0] irq_clear;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_inhibit_q <= updown_pkg::CTRL_RST_VAL[0];
    end else if (wr_commit && hit(address, updown_pkg::ADDR_CTRL)) begin
      ctrl_inhibit_q <= writedata[updown_pkg::CTRL_INHIBIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= updown_pkg::IRQ_MASK_RST;
    end else if (wr_commit && hit(address, updown_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_q <= writedata[updown_pkg::IRQ_N-1:0];
    end
  end

  assign irq_clear = (wr_commit && hit(address, updown_pkg::ADDR_IRQ_STAT))
                   ? writedata[updown_pkg::IRQ_N-1:0]
                   : '0;

  // A new event in the clearing cycle wins over the clear.
  for (genvar i = 0; i < updown_pkg::IRQ_N; i++) begin : g_irq
    always_ff @(posedge clk) begin
      if (rst) begin
        irq_stat_q[i] <= 1'b0;
      end else if (irq_event[i]) begin
        irq_stat_q[i] <= 1'b1;
      end else if (irq_clear[i]) begin
        irq_stat_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (address)
      updown_pkg::ADDR_CTRL: begin
        rd_mux[updown_pkg::CTRL_INHIBIT] = ctrl_inhibit_q;
      end
      updown_pkg::ADDR_STATUS: begin
        rd_mux[updown_pkg::STAT_STATE_LSB +: 4] = state_q;
        rd_mux[updown_pkg::STAT_TC]             = tc_q;
        rd_mux[updown_pkg::STAT_DOWN]           = down_s;
        rd_mux[updown_pkg::STAT_INHIBIT]        = inhibit;
        rd_mux[updown_pkg::STAT_RIPPLE_N]       = ~ripple_low_q;
      end
      updown_pkg::ADDR_IRQ_STAT: begin
        rd_mux[updown_pkg::IRQ_N-1:0] = irq_stat_q;
      end
      updown_pkg::ADDR_IRQ_MASK: begin
        rd_mux[updown_pkg::IRQ_N-1:0] = irq_mask_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Data is captured in the waiting cycle and held through the answer.
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= '0;
    end else if (read && !ack_q) begin
      readdata <= rd_mux;
    end
  end

endmodule // updown_counter

`default_nettype wire

/* File: test/updown_counter_props.sv */
// Concurrent checks on the up/down counter ports, bound to its top.
`default_nettype none

module updown_counter_props #(
  parameter bit DECADE  = 1'b1,
  parameter int STATE_W = 4
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clock_pulse,
  input wire logic        count_inhibit,
  input wire logic        down_select,
  input wire logic        preset_load_n,
  input wire logic [3:0]  preset_inputs,
  input wire logic [3:0]  state_outputs,
  input wire logic        terminal_count,
  input wire logic        ripple_clock_out,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TOP = DECADE ? updown_pkg::DECADE_MAX
                                      : updown_pkg::BINARY_MAX;
  // ****************************************************************
  // Pin history, bit n holds the value seen n+1 edges ago
  // ****************************************************************
  logic [2:0] age_q;
  logic [5:0] cp_q, inh_q, dn_q, ld_q, tc_q;
  logic       idle, rise3, dn_flat;

  always_ff @(posedge clk) begin
    if (rst) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    cp_q  <= {cp_q[4:0], clock_pulse};
    inh_q <= {inh_q[4:0], count_inhibit};
    dn_q  <= {dn_q[4:0], down_select};
    ld_q  <= {ld_q[4:0], preset_load_n};
    tc_q  <= {tc_q[4:0], terminal_count};
  end

  // Pins pass two synchronising stages, so a rise acts three edges on.
  assign idle    = (age_q == 3'h7) && (&ld_q) && preset_load_n;
  assign rise3   = cp_q[2] && !cp_q[3];
  assign dn_flat = dn_q == {6{down_select}};

  function automatic logic [3:0] nxt(input logic [3:0] s, input logic d);
    if (d) begin
      return (s == 4'h0 || s > TOP) ? TOP : s - 4'h1;
    end
    return (s >= TOP) ? 4'h0 : s + 4'h1;
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  step_on_rise_a:
    assert property (idle && $changed(state_outputs) |-> rise3)
    else $error("state moved without a count clock rise");
  inhibit_hold_a:
    assert property (idle && (&inh_q) |-> $stable(state_outputs))
    else $error("state moved while inhibited");
  step_up_a:
    assert property (idle && rise3 && !(|inh_q[4:1]) && !(|dn_q[4:1])
      |-> state_outputs == nxt($past(state_outputs), 1'b0))
    else $error("wrong up step");
  step_down_a:
    assert property (idle && rise3 && !(|inh_q[4:1]) && (&dn_q[4:1])
      |-> state_outputs == nxt($past(state_outputs), 1'b1))
    else $error("wrong down step");
  tc_decode_a:
    assert property (age_q == 3'h7 && $stable(state_outputs) && dn_flat
      |-> terminal_count == (down_select ? state_outputs == 4'h0
                                         : state_outputs == TOP))
    else $error("terminal count decode wrong");
  ripple_high_a:
    assert property (age_q == 3'h7 && ((&inh_q) || !(|tc_q))
      |-> ripple_clock_out)
    else $error("ripple low while inhibited or not terminal");
  ripple_low_a:
    assert property (idle && $fell(clock_pulse) && $stable(state_outputs)
      && terminal_count && !(|inh_q) && !count_inhibit && dn_flat
      |-> ##[2:4] !ripple_clock_out)
    else $error("ripple pulse missing");
  ripple_end_a:
    assert property (!ripple_clock_out && $rose(clock_pulse)
      |-> ##[2:4] ripple_clock_out)
    else $error("ripple pulse not ended by clock rise");
  preset_copy_a:
    assert property ((!preset_load_n && $stable(preset_inputs)) [*5]
      |-> state_outputs == preset_inputs)
    else $error("preset not copied");
  bus_wait_a:
    assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait cycle");

  cover property (idle && state_outputs == 4'h0 && $past(state_outputs) == TOP);
  cover property (!ripple_clock_out);
  cover property (!preset_load_n ##5 preset_load_n);
endmodule // updown_counter_props

bind updown_counter updown_counter_props #(
  .DECADE(DECADE), .STATE_W(STATE_W)
) i_updown_counter_props (
  .clk(clk), .rst(rst), .clock_pulse(clock_pulse),
  .count_inhibit(count_inhibit), .down_select(down_select),
  .preset_load_n(preset_load_n), .preset_inputs(preset_inputs),
  .state_outputs(state_outputs), .terminal_count(terminal_count),
  .ripple_clock_out(ripple_clock_out), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq)
);

`default_nettype wire

/* File: test/count_driver.sv */
// Behavioural count clock and control logic facing the counter pins.
`default_nettype none

module count_driver (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  input  wire logic       want_inh,
  input  wire logic       want_dn,
  output logic            clock_pulse,
  output logic            count_inhibit,
  output logic            down_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       tog;

  // Levels last half cycles, at least three, so carries settle while low.
  assign tog = run && cnt_q >= half - 4'h1;
  initial begin
    cnt_q = 4'h0;
    clock_pulse = 1'b0;
    count_inhibit = 1'b1;
    down_select = 1'b0;
  end
  // This single stage stands for the whole chain: its inhibit is the
  // enable term alone, the carry gate of a first stage.
  // Terminal count is only looked at, never used as a clock.
  always @(posedge clk) begin
    cnt_q <= tog ? 4'h0 : cnt_q + 4'h1;
    if (tog) clock_pulse <= !clock_pulse;
    if (!want_inh) count_inhibit <= 1'b0;
    else if (clock_pulse && !tog) count_inhibit <= 1'b1;
    if ((count_inhibit && want_inh) || (clock_pulse && !tog)) begin
      down_select <= want_dn;
    end
  end
endmodule // count_driver

`default_nettype wire

/* File: test/updown_counter_test.sv */
// Self-checking bench for the presettable up/down counter.
`default_nettype none

module updown_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int kind; logic [31:0] exp;} note_t;
  localparam logic [3:0] TOP = updown_pkg::DECADE_MAX;
  logic        clk = 1'b0, rst = 1'b1, run = 1'b0;
  logic        want_inh = 1'b1, want_dn = 1'b0, preset_load_n = 1'b1;
  logic        read = 1'b0, write = 1'b0;
  logic [3:0]  half = 4'h3, preset_inputs = 4'h0, address = 4'h0;
  logic [3:0]  byteenable = 4'h0, state_outputs, model;
  logic [31:0] writedata = 32'h0, rdata = 32'h0, readdata;
  logic        clock_pulse, count_inhibit, down_select, terminal_count;
  logic        ripple_clock_out, waitrequest, irq;
  note_t       notes[$];
  note_t       n;
  event        ev;
  int          mismatches = 0, checks = 0, seed = 15;

  always #4 clk = ~clk;

  count_driver i_count_driver (.clk(clk), .run(run), .half(half),
    .want_inh(want_inh), .want_dn(want_dn), .clock_pulse(clock_pulse),
    .count_inhibit(count_inhibit), .down_select(down_select));

  updown_counter #(.DECADE(1'b1)) i_updown_counter (.clk(clk), .rst(rst),
    .clock_pulse(clock_pulse), .count_inhibit(count_inhibit),
    .down_select(down_select), .preset_load_n(preset_load_n),
    .preset_inputs(preset_inputs), .state_outputs(state_outputs),
    .terminal_count(terminal_count), .ripple_clock_out(ripple_clock_out),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));

  // ****************************************************************
  // Scoreboard
  // ****************************************************************
  task automatic note(input int k, input logic [31:0] e);
    notes.push_back('{k, e});
    -> ev;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always begin
    @(ev);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.kind)
        0: check("state", {28'h0, state_outputs}, n.exp);
        1: check("tc", {31'h0, terminal_count}, n.exp);
        2: check("ripple", {31'h0, ripple_clock_out}, n.exp);
        3: check("irq", {31'h0, irq}, n.exp);
        default: check("readdata", rdata, n.exp);
      endcase
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d, input logic [31:0] m);
    int t;
    t = 0;
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= d;
    byteenable <= 4'hf;
    do begin
      @(posedge clk);
      t++;
    end while (waitrequest !== 1'b0 && t < 20);
    if (t >= 20) mismatches++;
    rdata = readdata & m;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Load runs while counting, so the preset has to win over steps.
  task automatic load(input logic [3:0] v);
    @(posedge clk);
    preset_inputs <= v;
    preset_load_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    note(0, v);
    note(3, 1'b1);
    preset_load_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus(updown_pkg::ADDR_IRQ_STAT, 1'b1, 32'h4, 32'h0);
    @(posedge clk);
    #1;
    note(3, 1'b0);
    model = v;
  endtask

  function automatic logic [3:0] nxt(input logic [3:0] s, input logic d);
    if (d) return (s == 4'h0 || s > TOP) ? TOP : s - 4'h1;
    return (s >= TOP) ? 4'h0 : s + 4'h1;
  endfunction

  task automatic steps(input int cnt);
    logic tc;
    @(negedge clock_pulse);
    want_inh <= 1'b0;
    repeat (cnt) begin
      @(posedge clock_pulse);
      repeat (5) @(posedge clk);
      #1;
      model = nxt(model, want_dn);
      tc = want_dn ? model == 4'h0 : model == TOP;
      note(0, model);
      note(1, tc);
      if (tc) begin
        repeat (2) @(posedge clk);
        #1;
        note(2, 1'b0);
      end
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    note(0, 4'h0);
    note(2, 1'b1);
    note(3, 1'b0);
    bus(4'h1, 1'b0, 32'h0, 32'hffff_ffff);
    note(4, 32'h0);
    bus(updown_pkg::ADDR_IRQ_MASK, 1'b1, 32'h4, 32'h0);
    bus(updown_pkg::ADDR_IRQ_MASK, 1'b0, 32'h0, 32'hffff_ffff);
    note(4, 32'h4);
    run <= 1'b1;
    want_inh <= 1'b0;
    repeat (4) load(4'(($random(seed) & 32'h7fff_ffff) % 10));
    want_inh <= 1'b1;
    half <= 4'h4;
    load(4'h8);
    steps(10);
    want_inh <= 1'b1;
    model = nxt(model, 1'b0);
    repeat (40) @(posedge clk);
    #1;
    note(0, model);
    note(1, 1'b1);
    note(2, 1'b1);
    bus(updown_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'hffff_ffff);
    note(4, 32'hd9);
    bus(updown_pkg::ADDR_CTRL, 1'b1, 32'h1, 32'h0);
    bus(updown_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'hffff_ffff);
    note(4, 32'h1);
    bus(updown_pkg::ADDR_CTRL, 1'b1, 32'h0, 32'h0);
    bus(updown_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'hffff_ffff);
    note(4, 32'h0);
    want_dn <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    note(1, 1'b0);
    steps(12);
    want_inh <= 1'b1;
    load(4'hc);
    want_dn <= 1'b0;
    repeat (20) @(posedge clk);
    steps(1);
    summarize();
  end

  initial begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule // updown_counter_test

`default_nettype wire
